// ==== src/cpfm_pin_mux.sv ====
// Configurable pin function mux with bit-bang control of the shared data lines.
// Assumes one 50 MHz clock, a classic Wishbone master, a configuration memory
// read port and USB engine status on the same clock; pins arrive unsynchronised.
//
// Function
// - Pin floats, drives constant one or constant zero per option.
// - Exactly one configurable pin whose function comes from configuration memory.
// - One function at a time, taken from configuration memory bits.
// - Power enable drives low once configured, high during suspend.
// - Sleep indicator drives low during suspend, high otherwise.
// - Clock options give a free-running 24, 12 or 6 MHz clock.
// - Any clock output stops while in suspend.
// - GPIO option lets software drive and read the pin.
// - Charger option drives high while on a dedicated charging port.
// - Inverted charger option drives the complement of that indication.
// - Write strobe option gives an active-low strobe per output update.
// - Read strobe option gives an active-low strobe per input sample.
// - Bus power sense option reads the pin as bus power present.
// - Time stamp option toggles the pin on each start of frame.
// - Keep-awake option holding the pin low blocks suspend entry.
// - Bit-bang modes turn the eight data lines into a general port.
// - Asynchronous mode paces received bytes out by a prescaler timer.
// - Synchronous mode samples the port only when a byte is written.
// - Data inputs pull low in suspend when configured, else pull high.
`timescale 1ns/1ps
`include "cpfm_defines.svh"
module cpfm_pin_mux
   import cpfm_pkg::*;
#(
   parameter int DIV_W = 16
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic wb_cyc,
   input wire logic wb_stb,
   input wire logic wb_we,
   input wire logic [7:0] wb_adr,
   input wire logic [3:0] wb_sel,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack,
   output logic nvm_rd_req,
   input wire logic nvm_rd_ack,
   input wire logic [7:0] nvm_rd_data,
   input wire logic usb_configured,
   input wire logic usb_suspend,
   input wire logic usb_sof,
   input wire logic charger_attached,
   output logic suspend_inhibit,
   output logic bus_power_present,
   input wire logic config_pin_in,
   output logic config_pin_out,
   output logic config_pin_oe,
   input wire logic [7:0] proto_data_out,
   input wire logic [7:0] proto_data_oe,
   output logic [7:0] proto_data_in,
   input wire logic [7:0] shared_data_lines_in,
   output logic [7:0] shared_data_lines_out,
   output logic [7:0] shared_data_lines_oe,
   output logic data_pull_low,
   output logic bitbang_active,
   input wire logic rx_valid,
   input wire logic [7:0] rx_data,
   output logic rx_ready,
   output logic tx_valid,
   output logic [7:0] tx_data,
   input wire logic tx_ready
);

   // Phase increments for the clock synthesiser, 2^32 * f / fclk
   localparam logic [31:0] INC_FAST = 32'((64'(`CPFM_FAST_HZ) << 32) / 64'(`CPFM_CLK_HZ));
   localparam logic [31:0] INC_MID = 32'((64'(`CPFM_MID_HZ) << 32) / 64'(`CPFM_CLK_HZ));
   localparam logic [31:0] INC_SLOW = 32'((64'(`CPFM_SLOW_HZ) << 32) / 64'(`CPFM_CLK_HZ));

   logic pin_meta;
   logic pin_sync;
   logic [7:0] data_meta;
   logic [7:0] data_sync;
   cpfm_load_t load_state;
   cpfm_opt_t opt;
   logic nvm_pull_low;
   logic gpio_out;
   logic gpio_oe;
   logic [1:0] bb_mode;
   logic [DIV_W-1:0] bb_div;
   logic [DIV_W-1:0] bb_count;
   logic [7:0] bb_dir;
   logic [7:0] bb_out;
   logic wr_pulse;
   logic rd_pulse;
   logic ts_level;
   logic [31:0] clk_acc;
   logic next_pin_out;
   logic next_pin_oe;

   // Pin synchronisers; the first stage feeds only the second
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         pin_meta <= 1'b0;
         pin_sync <= 1'b0;
         data_meta <= 8'h00;
         data_sync <= 8'h00;
      end else begin
         pin_meta <= config_pin_in;
         pin_sync <= pin_meta;
         data_meta <= shared_data_lines_in;
         data_sync <= data_meta;
      end
   end

   // Option load: pin stays floating until the memory word arrives
   wire loaded = (load_state == LOAD_DONE);
   assign nvm_rd_req = (load_state == LOAD_WAIT);

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         load_state <= LOAD_WAIT;
         opt <= OPT_TRISTATE;
         nvm_pull_low <= 1'b0;
      end else begin
         unique case (load_state)
            LOAD_WAIT: begin
               if (nvm_rd_ack) begin
                  opt <= cpfm_opt_t'(nvm_rd_data[`CPFM_NVM_OPT_MSB:`CPFM_NVM_OPT_LSB]);
                  nvm_pull_low <= nvm_rd_data[`CPFM_NVM_PULL_BIT];
                  load_state <= LOAD_DONE;
               end
            end
            LOAD_DONE: ;
         endcase
      end
   end

   // Wishbone decode; a write commits at the edge that sees ack
   wire wb_req = wb_cyc & wb_stb;
   wire wb_wr = wb_req & wb_we & wb_ack;
   wire hit_status = (wb_adr == `CPFM_REG_STATUS);
   wire hit_gpio = (wb_adr == `CPFM_REG_GPIO);
   wire hit_bb_ctrl = (wb_adr == `CPFM_REG_BB_CTRL);
   wire hit_bb_div = (wb_adr == `CPFM_REG_BB_DIV);
   wire hit_bb_data = (wb_adr == `CPFM_REG_BB_DATA);
   wire hit_bb_dir = (wb_adr == `CPFM_REG_BB_DIR);
   wire wr_lane0 = wb_wr & wb_sel[0];

   // Read mux; unmapped offsets read zero but still acknowledge
   wire [31:0] rd_status = {21'h0, usb_suspend, charger_attached, ts_level, suspend_inhibit,
                            bus_power_present, pin_sync, loaded, opt};
   wire [31:0] rd_gpio = {23'h0, pin_sync, 6'h00, gpio_oe, gpio_out};
   wire [31:0] rd_mux = hit_status ? rd_status :
                        hit_gpio ? rd_gpio :
                        hit_bb_ctrl ? {30'h0, bb_mode} :
                        hit_bb_div ? 32'(bb_div) :
                        hit_bb_data ? {24'h000000, tx_data} :
                        hit_bb_dir ? {24'h000000, bb_dir} : 32'h00000000;

   // Ack one cycle after the request, dropped the cycle after
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         wb_ack <= 1'b0;
         wb_dat_o <= 32'h00000000;
      end else begin
         wb_ack <= wb_req & ~wb_ack;
         if (wb_req & ~wb_ack) begin
            wb_dat_o <= rd_mux;
         end
      end
   end

   // Software registers; the lane 0 select gates every field, bb_div bits 15:8 included
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         gpio_out <= 1'b0;
         gpio_oe <= 1'b0;
         bb_mode <= BB_OFF;
         bb_div <= DIV_W'(`CPFM_BB_DIV_RST);
         bb_dir <= `CPFM_BB_DIR_RST;
      end else begin
         if (wr_lane0 & hit_gpio) begin
            gpio_out <= wb_dat_i[`CPFM_GPIO_OUT_BIT];
            gpio_oe <= wb_dat_i[`CPFM_GPIO_OE_BIT];
         end
         if (wr_lane0 & hit_bb_ctrl) begin
            bb_mode <= wb_dat_i[1:0];
         end
         if (wr_lane0 & hit_bb_div) begin
            bb_div <= wb_dat_i[DIV_W-1:0];
         end
         if (wr_lane0 & hit_bb_dir) begin
            bb_dir <= wb_dat_i[7:0];
         end
      end
   end

   // Bit-bang mode decode and pacing
   wire bb_async = (bb_mode == BB_ASYNC);
   wire bb_sync = (bb_mode == BB_SYNC);
   wire bb_tick = bb_async & (bb_count >= bb_div);
   // A pending sample stalls the byte source so no read-back is lost
   assign rx_ready = ~tx_valid & (bb_sync | bb_tick);
   wire rx_fire = rx_valid & rx_ready;
   // Synchronous mode samples only with a written byte
   wire sample_fire = bb_sync ? rx_fire : (bb_tick & ~tx_valid);
   assign bitbang_active = bb_async | bb_sync;

   // Prescaler counter, restarted at each tick
   always_ff @(posedge clk) begin
      if (sys_rst | ~bb_async | bb_tick) begin
         bb_count <= '0;
      end else begin
         bb_count <= bb_count + 1'b1;
      end
   end

   // Output byte, read-back and strobes
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         bb_out <= 8'h00;
         tx_valid <= 1'b0;
         tx_data <= 8'h00;
         wr_pulse <= 1'b0;
         rd_pulse <= 1'b0;
      end else begin
         if (rx_fire) begin
            bb_out <= rx_data;
         end
         if (sample_fire) begin
            tx_valid <= 1'b1;
            tx_data <= data_sync;
         end else if (tx_ready) begin
            tx_valid <= 1'b0;
         end
         wr_pulse <= rx_fire;
         rd_pulse <= sample_fire;
      end
   end

   // Data lines: bit-bang port or the protocol engine, registered
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         shared_data_lines_out <= 8'h00;
         shared_data_lines_oe <= 8'h00;
      end else begin
         shared_data_lines_out <= bitbang_active ? bb_out : proto_data_out;
         shared_data_lines_oe <= bitbang_active ? bb_dir : proto_data_oe;
      end
   end
   assign proto_data_in = data_sync;

   // Clock synthesiser; average rate exact, edges jitter by one clk period
   wire clk_opt = (opt == OPT_CLK_FAST) | (opt == OPT_CLK_MID) | (opt == OPT_CLK_SLOW);
   wire clk_run = loaded & clk_opt & ~usb_suspend;
   wire [31:0] clk_inc = (opt == OPT_CLK_FAST) ? INC_FAST :
                         (opt == OPT_CLK_MID) ? INC_MID : INC_SLOW;

   always_ff @(posedge clk) begin
      if (sys_rst | ~clk_run) begin
         clk_acc <= 32'h00000000;
      end else begin
         clk_acc <= clk_acc + clk_inc;
      end
   end

   // Frame toggle
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         ts_level <= 1'b0;
      end else if (usb_sof) begin
         ts_level <= ~ts_level;
      end
   end

   // Pin function select
   always_comb begin
      next_pin_oe = 1'b1;
      next_pin_out = 1'b0;
      unique case (opt)
         OPT_TRISTATE: next_pin_oe = 1'b0;
         OPT_DRIVE_HIGH: next_pin_out = 1'b1;
         OPT_DRIVE_LOW: next_pin_out = 1'b0;
         OPT_POWER_EN: next_pin_out = ~(usb_configured & ~usb_suspend);
         OPT_SLEEP: next_pin_out = ~usb_suspend;
         OPT_CLK_FAST,
         OPT_CLK_MID,
         OPT_CLK_SLOW: next_pin_out = clk_acc[31];
         OPT_GPIO: begin
            next_pin_oe = gpio_oe;
            next_pin_out = gpio_out;
         end
         OPT_CHARGER: next_pin_out = charger_attached;
         OPT_CHARGER_N: next_pin_out = ~charger_attached;
         OPT_WR_STROBE: next_pin_out = ~wr_pulse;
         OPT_RD_STROBE: next_pin_out = ~rd_pulse;
         OPT_BUS_SENSE: next_pin_oe = 1'b0;
         OPT_TIME_STAMP: next_pin_out = ts_level;
         OPT_KEEP_AWAKE: next_pin_oe = 1'b0;
      endcase
   end

   // The single pin and the sensed levels, all registered
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         config_pin_out <= 1'b0;
         config_pin_oe <= 1'b0;
         bus_power_present <= 1'b0;
         suspend_inhibit <= 1'b0;
         data_pull_low <= 1'b0;
      end else begin
         config_pin_out <= next_pin_out;
         config_pin_oe <= next_pin_oe;
         // Without sensing the bus is taken as powered
         bus_power_present <= (loaded & (opt == OPT_BUS_SENSE)) ? pin_sync : 1'b1;
         suspend_inhibit <= (opt == OPT_KEEP_AWAKE) & ~pin_sync;
         data_pull_low <= nvm_pull_low & usb_suspend;
      end
   end

   // Checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   property p_tristate;
      (opt == OPT_TRISTATE) |=> !config_pin_oe;
   endproperty
   a_tristate: assert property (p_tristate) else $error("pin driven in floating option");

   property p_drive_high;
      (opt == OPT_DRIVE_HIGH) |=> (config_pin_oe && config_pin_out);
   endproperty
   a_drive_high: assert property (p_drive_high) else $error("constant one not driven");

   property p_no_drive_unloaded;
      !loaded |=> !config_pin_oe;
   endproperty
   a_no_drive_unloaded: assert property (p_no_drive_unloaded) else $error("pin driven before option load");

   property p_power_en;
      (opt == OPT_POWER_EN && usb_configured && !usb_suspend) ##1 (opt == OPT_POWER_EN && usb_suspend)
         |=> config_pin_out;
   endproperty
   a_power_en: assert property (p_power_en) else $error("power enable not high in suspend");

   property p_sleep;
      (opt == OPT_SLEEP) |=> (config_pin_out == !$past(usb_suspend));
   endproperty
   a_sleep: assert property (p_sleep) else $error("sleep indicator wrong");

   property p_clk_runs;
      clk_opt && loaded && !usb_suspend |=> (clk_acc != $past(clk_acc));
   endproperty
   a_clk_runs: assert property (p_clk_runs) else $error("clock synthesiser stalled");

   property p_clk_stops;
      (clk_opt && usb_suspend) [*2] |=> !config_pin_out;
   endproperty
   a_clk_stops: assert property (p_clk_stops) else $error("clock output in suspend");

   property p_wr_strobe;
      (rx_fire && opt == OPT_WR_STROBE) |=> ##1 !config_pin_out ##1 (config_pin_out || $past(rx_fire, 2));
   endproperty
   a_wr_strobe: assert property (p_wr_strobe) else $error("write strobe missing");

   property p_time_stamp;
      usb_sof |=> (ts_level != $past(ts_level));
   endproperty
   a_time_stamp: assert property (p_time_stamp) else $error("frame toggle missed");

   property p_keep_awake;
      (opt == OPT_KEEP_AWAKE && !config_pin_in) [*4] |=> suspend_inhibit;
   endproperty
   a_keep_awake: assert property (p_keep_awake) else $error("suspend not inhibited");

   property p_port_out;
      (bitbang_active && rx_fire) |=> ##1 (shared_data_lines_out == $past(rx_data, 2));
   endproperty
   a_port_out: assert property (p_port_out) else $error("bit-bang byte not on data lines");

   property p_async_pace;
      (rx_fire && bb_async && bb_div != '0) |=> !rx_fire;
   endproperty
   a_async_pace: assert property (p_async_pace) else $error("bytes not paced by timer");

   property p_sync_sample;
      (bb_sync && $rose(tx_valid)) |-> $past(rx_fire);
   endproperty
   a_sync_sample: assert property (p_sync_sample) else $error("sample without write");

   property p_pull_low;
      (nvm_pull_low && usb_suspend) |=> data_pull_low;
   endproperty
   a_pull_low: assert property (p_pull_low) else $error("suspend pull-down missing");

endmodule

// ==== src/cpfm_defines.svh ====
// Constants for the configurable pin function mux: register offsets,
// configuration memory field positions, reset values and clock figures.
// Assumes a 50 MHz system clock and byte addresses on a 32-bit Wishbone bus.
`ifndef CPFM_DEFINES_SVH
`define CPFM_DEFINES_SVH

// System clock and the three pin clock rates, in hertz
`define CPFM_CLK_HZ 50000000
`define CPFM_FAST_HZ 24000000
`define CPFM_MID_HZ 12000000
`define CPFM_SLOW_HZ 6000000

// Register byte offsets
`define CPFM_REG_STATUS 8'h00
`define CPFM_REG_GPIO 8'h04
`define CPFM_REG_BB_CTRL 8'h08
`define CPFM_REG_BB_DIV 8'h0C
`define CPFM_REG_BB_DATA 8'h10
`define CPFM_REG_BB_DIR 8'h14

// Configuration memory word layout
`define CPFM_NVM_OPT_LSB 0
`define CPFM_NVM_OPT_MSB 3
`define CPFM_NVM_PULL_BIT 4

// GPIO register field positions
`define CPFM_GPIO_OUT_BIT 0
`define CPFM_GPIO_OE_BIT 1

// Reset values
`define CPFM_BB_DIV_RST 16'h0010
`define CPFM_BB_DIR_RST 8'h00

`endif

// ==== src/cpfm_pkg.sv ====
// Types for the configurable pin function mux.
// Pin option codes follow the declaration order below (0 to 15).
package cpfm_pkg;

   // Pin function held in configuration memory
   typedef enum logic [3:0] {
      OPT_TRISTATE,
      OPT_DRIVE_HIGH,
      OPT_DRIVE_LOW,
      OPT_POWER_EN,
      OPT_SLEEP,
      OPT_CLK_FAST,
      OPT_CLK_MID,
      OPT_CLK_SLOW,
      OPT_GPIO,
      OPT_CHARGER,
      OPT_CHARGER_N,
      OPT_WR_STROBE,
      OPT_RD_STROBE,
      OPT_BUS_SENSE,
      OPT_TIME_STAMP,
      OPT_KEEP_AWAKE
   } cpfm_opt_t;

   // Option load sequence after reset
   typedef enum logic {
      LOAD_WAIT,
      LOAD_DONE
   } cpfm_load_t;

   // Bit-bang mode of the shared data lines; code 3 acts as off
   typedef enum logic [1:0] {
      BB_OFF,
      BB_ASYNC,
      BB_SYNC
   } cpfm_bb_t;

endpackage

// ==== dv/cpfm_board_model.sv ====
// Board side of the pin mux: configuration memory and pin/data line wiring.
// Assumes the bench sets the stored word and any external drive on the pin.
`timescale 1ns/1ps
module cpfm_board_model (
   input wire logic clk,
   input wire logic nvm_rd_req,
   output logic nvm_rd_ack,
   output logic [7:0] nvm_rd_data,
   input wire logic [7:0] word,
   input wire logic pin_out,
   input wire logic pin_oe,
   input wire logic ext_en,
   input wire logic ext_val,
   output logic pin_in,
   input wire logic [7:0] lines_out,
   input wire logic [7:0] lines_oe,
   output logic [7:0] lines_in
);
   int wait_cnt;
   initial begin
      nvm_rd_ack = 1'b0;
      wait_cnt = 0;
   end
   // Memory answers late, once per request; data is junk outside the strobe
   always @(posedge clk) begin
      nvm_rd_ack <= nvm_rd_req && wait_cnt == 4;
      wait_cnt <= nvm_rd_req ? wait_cnt + 1 : 0;
   end
   assign nvm_rd_data = nvm_rd_ack ? word : ~word;
   // Pins are pulled up when nobody drives them
   assign pin_in = pin_oe ? pin_out : (ext_en ? ext_val : 1'b1);
   assign lines_in = (lines_oe & lines_out) | ~lines_oe;
endmodule

// ==== dv/cpfm_pin_mux_tb.sv ====
// Self-checking bench for the configurable pin function mux.
// Assumes the board model answers the option read; every scenario reloads it.
`timescale 1ns/1ps
`include "cpfm_defines.svh"
module cpfm_pin_mux_tb;
   import cpfm_pkg::*;
   logic clk, sys_rst = 1, wb_cyc = 0, wb_stb = 0, wb_we = 0, wb_ack;
   logic [7:0] wb_adr = 0, nvm_rd_data, word = 0, proto_data_in, rx_data = 0, tx_data;
   logic [3:0] wb_sel = 4'h0;
   logic [7:0] proto_data_out = 8'h5A, proto_data_oe = 8'hC3;
   logic [31:0] wb_dat_i = 0, wb_dat_o, q;
   logic nvm_rd_req, nvm_rd_ack, usb_configured = 0, usb_suspend = 0, usb_sof = 0;
   logic charger_attached = 0, suspend_inhibit, bus_power_present, config_pin_in;
   logic config_pin_out, config_pin_oe, data_pull_low, bitbang_active;
   logic rx_valid = 0, rx_ready, tx_valid, tx_ready = 1, ext_en = 1, ext_val = 1;
   logic [7:0] shared_data_lines_in, shared_data_lines_out, shared_data_lines_oe;
   int fails = 0, num_checks = 0, c, s, t;
   cpfm_pin_mux DUT (.clk, .sys_rst, .wb_cyc, .wb_stb, .wb_we, .wb_adr, .wb_sel, .wb_dat_i,
      .wb_dat_o, .wb_ack, .nvm_rd_req, .nvm_rd_ack, .nvm_rd_data, .usb_configured, .usb_suspend,
      .usb_sof, .charger_attached, .suspend_inhibit, .bus_power_present, .config_pin_in,
      .config_pin_out, .config_pin_oe, .proto_data_out, .proto_data_oe,
      .proto_data_in, .shared_data_lines_in, .shared_data_lines_out, .shared_data_lines_oe,
      .data_pull_low, .bitbang_active, .rx_valid, .rx_data, .rx_ready, .tx_valid, .tx_data,
      .tx_ready);
   cpfm_board_model board (.clk, .nvm_rd_req, .nvm_rd_ack, .nvm_rd_data, .word,
      .pin_out(config_pin_out), .pin_oe(config_pin_oe), .ext_en, .ext_val, .pin_in(config_pin_in),
      .lines_out(shared_data_lines_out), .lines_oe(shared_data_lines_oe),
      .lines_in(shared_data_lines_in));
   initial begin
      clk = 0;
      forever #10 clk = ~clk;
   end
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         fails++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic end_sim;
      $display("checks=%0d fails=%0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask
   // Classic single cycle; request held until ack is seen at an edge
   task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] d);
      wb_cyc <= 1;
      wb_stb <= 1;
      wb_we <= we;
      wb_sel <= 4'hF;
      wb_adr <= adr;
      wb_dat_i <= d;
      // No answer time assumed; the watchdog ends a hung wait
      do begin
         @(posedge clk);
      end while (wb_ack !== 1'b1);
      q = wb_dat_o;
      wb_cyc <= 0;
      wb_stb <= 0;
      tick(1);
   endtask
   // Reset for 3 cycles, then wait for the option read to finish
   task automatic load(input logic [7:0] w);
      int n;
      word <= w;
      sys_rst <= 1;
      tick(3);
      sys_rst <= 0;
      tick(3);
      check(config_pin_oe, 0);
      n = 0;
      while (nvm_rd_req !== 1'b0 && n < 50) begin
         tick(1);
         n++;
      end
      if (n >= 50) fails++;
      tick(3);
   endtask
   // Count rising edges of the pin drive over n cycles
   task automatic rises(input int n);
      logic last;
      c = 0;
      last = config_pin_out;
      repeat (n) begin
         @(posedge clk);
         if (config_pin_out === 1'b1 && last === 1'b0) c++;
         last = config_pin_out;
      end
   endtask
   // Hand over one byte, then watch the strobe and the returned sample
   task automatic send(input logic [7:0] b);
      int n;
      n = 0;
      rx_valid <= 1;
      rx_data <= b;
      do begin
         @(posedge clk);
         n++;
      end while (!(rx_valid && rx_ready === 1'b1) && n < 50);
      if (n >= 50) fails++;
      rx_valid <= 0;
      c = 0;
      repeat (8) begin
         @(posedge clk);
         if (config_pin_out !== 1'b1) c++;
         if (tx_valid === 1'b1) s = tx_data;
      end
   endtask
   task automatic t_static;
      load(OPT_TRISTATE);
      check(config_pin_oe, 0);
      load(OPT_DRIVE_HIGH);
      check({config_pin_oe, config_pin_out}, 2'b11);
      load(OPT_DRIVE_LOW);
      check({config_pin_oe, config_pin_out}, 2'b10);
      load(OPT_POWER_EN);
      check(config_pin_out, 1);
      usb_configured <= 1;
      tick(3);
      check(config_pin_out, 0);
      usb_suspend <= 1;
      tick(3);
      check(config_pin_out, 1);
      load(OPT_SLEEP);
      check(config_pin_out, 0);
      usb_suspend <= 0;
      tick(3);
      check(config_pin_out, 1);
      for (int k = 0; k < 2; k++) begin
         load(k ? OPT_CHARGER_N : OPT_CHARGER);
         for (int v = 0; v < 2; v++) begin
            charger_attached <= v[0];
            tick(3);
            check(config_pin_out, v[0] ^ k[0]);
         end
      end
      $display("test static done");
   endtask
   task automatic t_clock;
      for (int i = 0; i < 3; i++) begin
         load(8'(5 + i));
         rises(100);
         check(c >= (48 >> i) - 1 && c <= (48 >> i) + 1, 1);
         usb_suspend <= 1;
         tick(2);
         rises(50);
         check(c, 0);
         check(data_pull_low, 0);
         usb_suspend <= 0;
      end
      $display("test clock done");
   endtask
   task automatic t_gpio;
      load(OPT_GPIO);
      wb(0, `CPFM_REG_STATUS, 0);
      check(q[4:0], {1'b1, OPT_GPIO});
      wb(1, `CPFM_REG_GPIO, 32'h3);
      tick(2);
      check({config_pin_oe, config_pin_out}, 2'b11);
      wb(1, `CPFM_REG_GPIO, 32'h0);
      for (int v = 0; v < 2; v++) begin
         ext_val <= v[0];
         tick(5);
         wb(0, `CPFM_REG_GPIO, 0);
         check(q[8], v[0]);
      end
      wb(0, 8'hFC, 0);
      check(q, 0);
      $display("test gpio done");
   endtask
   task automatic t_inputs;
      for (int k = 0; k < 2; k++) begin
         load(k ? OPT_KEEP_AWAKE : OPT_BUS_SENSE);
         for (int v = 0; v < 2; v++) begin
            ext_val <= v[0];
            tick(6);
            if (k) check(suspend_inhibit, !v[0]);
            else check({config_pin_oe, bus_power_present}, v[0]);
         end
      end
      load(OPT_TIME_STAMP);
      repeat (2) begin
         t = config_pin_out;
         usb_sof <= 1;
         tick(1);
         usb_sof <= 0;
         tick(4);
         check(config_pin_out, !t[0]);
      end
      load(8'h10);
      usb_suspend <= 1;
      tick(3);
      check(data_pull_low, 1);
      usb_suspend <= 0;
      tick(3);
      check(data_pull_low, 0);
      $display("test inputs done");
   endtask
   task automatic t_bitbang;
      for (int k = 0; k < 2; k++) begin
         load(k ? OPT_RD_STROBE : OPT_WR_STROBE);
         // Bit-bang off: lines belong to the protocol engine
         check({shared_data_lines_oe, shared_data_lines_out}, 16'hC35A);
         check(proto_data_in, 8'h7E);
         wb(0, `CPFM_REG_BB_DIV, 0);
         check(q[15:0], `CPFM_BB_DIV_RST);
         wb(1, `CPFM_REG_BB_DIR, 32'hFF);
         wb(1, `CPFM_REG_BB_CTRL, 32'h2);
         tick(20);
         check({bitbang_active, tx_valid}, 2'b10);
         send(8'hA5);
         check({c[7:0], s[7:0]}, 16'h0100);
         check(shared_data_lines_out, 8'hA5);
         send(8'h3C);
         check({c[7:0], s[7:0]}, 16'h01A5);
      end
      wb(1, `CPFM_REG_BB_DIV, 32'h3);
      wb(1, `CPFM_REG_BB_CTRL, 32'h1);
      rx_valid <= 1;
      rx_data <= 8'h96;
      s = -1;
      t = -1;
      for (int i = 0; i < 40; i++) begin
         @(posedge clk);
         if (rx_ready === 1'b1 && s < 0) s = i;
         else if (rx_ready === 1'b1 && t < 0) t = i;
      end
      rx_valid <= 0;
      check(t - s, 4);
      check(shared_data_lines_out, 8'h96);
      $display("test bitbang done");
   endtask
   initial begin
      #400000;
      fails++;
      end_sim;
   end
   initial begin
      t_static;
      t_clock;
      t_gpio;
      t_inputs;
      t_bitbang;
      end_sim;
   end
endmodule
